// ### ispp_pkg.sv
// Shared constants and types for the serial programming port
package ispp_pkg;
   localparam int ROW_DATA_BITS = 82;
   localparam int ROW_ADDR_BITS = 6;
   localparam int ROW_BITS      = ROW_DATA_BITS + ROW_ADDR_BITS;
   localparam int NUM_ROWS      = 64;
   localparam int MC_BITS       = 8;
   localparam int PROG_TIME_MS  = 10;
   localparam logic [ROW_BITS-1:0] SHIFT_RESET = 88'h0;
   localparam logic [MC_BITS-1:0]  MC_RESET    = 8'h00;

   typedef enum logic [2:0] {
      ISPP_NORMAL,
      ISPP_PRELOAD,
      ISPP_SHIFT,
      ISPP_READ,
      ISPP_WRITE
   } ispp_state_e;

   // Link pins sampled on the diagnostic clock
   typedef struct packed {
      logic mode;
      logic serial_in;
   } ispp_pins_s;

   // Row write request handed to the array
   typedef struct packed {
      logic                     active;
      logic [ROW_ADDR_BITS-1:0] addr;
      logic [ROW_DATA_BITS-1:0] data;
   } ispp_wr_s;
endpackage

// ### ispp_sync.sv
// Two-flop level synchroniser into the domain of its clk input
`timescale 1ns/1ns
module ispp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ispp_sync_s;

   ispp_sync_s st_ff;
   ispp_sync_s nxt_st;

   // Next value: first stage feeds only the second
   always_comb
   begin
      nxt_st    = st_ff;
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
   end

   // Register
   always_ff @(posedge clk)
   begin
      if (!rstn)
         st_ff <= '0;
      else if (ce)
         st_ff <= nxt_st;
   end

   assign q = st_ff.s2;
endmodule

// ### ispp_port.sv
// Serial programming and diagnostic port controller
//
// Summary of operation
// - Reset forces the normal state so no array write happens at power-up.
// - Mode high with serial_in low at any clock returns to normal.
// - Besides normal: preload, program shift, program read, program write states.
// - Mode and serial_in high step normal to preload, then to shift.
// - In shift with mode low each clock shifts one bit of 88.
// - Old shift contents leave on serial_out while new bits enter.
// - Both high step shift to read then write; write starts on entry.
// - Mode low, serial_in high in write returns to read, ending the pulse.
// - In read the addressed row is loaded in parallel into the shift register.
// - Read to shift with mode low performs the verify load of the row.
// - Host shifts the next word in while watching read-back data out.
// - Write programs the row from the shift register, which stays unchanged.
// - Programming spans two clock edges; host spaces them ten milliseconds.
// - Preload entry captures macrocells, then shifts test data each clock.
// - In preload serial_in enters at bit zero and data leaves on serial_out.
// - Back in normal the macrocells resume from preloaded values.
// - Normal state runs from the last written configuration.
`timescale 1ns/1ns
module ispp_port (
   // System clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire logic                                  ce,
   // Serial link, clocked by the diagnostic clock
   input  wire logic                                  diag_clock,
   input  wire logic                                  mode,
   input  wire logic                                  serial_in,
   output logic                                       serial_out,
   // Macrocell interface
   input  wire logic [ispp_pkg::MC_BITS-1:0]          mc_state,
   output logic      [ispp_pkg::MC_BITS-1:0]          mc_preload,
   output logic                                       mc_preload_valid,
   // Array row being read, addressed by the shift register address field
   output logic      [ispp_pkg::ROW_ADDR_BITS-1:0]    row_addr,
   input  wire logic [ispp_pkg::ROW_DATA_BITS-1:0]    row_rdata,
   // Array write strobe in the system clock domain
   output logic                                       row_write,
   output logic      [ispp_pkg::ROW_ADDR_BITS-1:0]    row_waddr,
   output logic      [ispp_pkg::ROW_DATA_BITS-1:0]    row_wdata,
   // Controller state and configuration valid flag
   output logic      [2:0]                            port_state,
   output logic                                       normal_mode
);
   localparam int RB = ispp_pkg::ROW_BITS;
   localparam int DB = ispp_pkg::ROW_DATA_BITS;
   localparam int MB = ispp_pkg::MC_BITS;

   // Link-domain state, clocked by diag_clock
   typedef struct packed {
      ispp_pkg::ispp_state_e  state;
      logic [RB-1:0]          shreg;
      logic [MB-1:0]          mcreg;
      logic                   sout;
      logic                   wr_active;
      logic                   pre_done;
   } ispp_link_s;

   // System-domain state, clocked by clk
   typedef struct packed {
      logic [2:0]             wr_sync;
      logic                   write;
      logic [ispp_pkg::ROW_ADDR_BITS-1:0] waddr;
      logic [DB-1:0]          wdata;
      logic [2:0]             state_out;
      logic [2:0]             st_prev;
      logic                   normal;
      logic [MB-1:0]          mc_out;
      logic                   mc_valid;
      logic [ispp_pkg::ROW_ADDR_BITS-1:0] raddr;
   } ispp_sys_s;

   ispp_link_s lk_ff;
   ispp_link_s nxt_lk;
   ispp_sys_s  sy_ff;
   ispp_sys_s  nxt_sy;

   // Link reset brought into the diagnostic clock domain
   logic [1:0] lrst_ff;
   logic       link_rstn;

   // Link-to-system status crossing
   logic [2:0] state_sync;
   logic       wr_level_sync;
   logic       pre_sync;

   // Macrocell state brought onto diag_clock
   logic [MB-1:0] mc_sync;

   // Returns the address field held in the low end of the shift register
   function automatic logic [ispp_pkg::ROW_ADDR_BITS-1:0] addr_of(input logic [RB-1:0] s);
      addr_of = s[ispp_pkg::ROW_ADDR_BITS-1:0];
   endfunction

   // Returns the data field held above the address field
   function automatic logic [DB-1:0] data_of(input logic [RB-1:0] s);
      data_of = s[RB-1:ispp_pkg::ROW_ADDR_BITS];
   endfunction

   // Reset release synchronised onto diag_clock
   always_ff @(posedge diag_clock or negedge rstn)
   begin
      if (!rstn)
         lrst_ff <= 2'h0;
      else
         lrst_ff <= {lrst_ff[0], 1'b1};
   end
   assign link_rstn = lrst_ff[1];

   // Link state machine and shift path
   always_comb
   begin
      nxt_lk = lk_ff;
      if (mode && !serial_in)
      begin
         nxt_lk.state     = ispp_pkg::ISPP_NORMAL;
         nxt_lk.wr_active = 1'b0;
      end
      else
      begin
         unique case (lk_ff.state)
            ispp_pkg::ISPP_NORMAL:
            begin
               if (mode)
               begin
                  nxt_lk.state = ispp_pkg::ISPP_PRELOAD;
                  nxt_lk.mcreg = mc_sync;
               end
            end
            ispp_pkg::ISPP_PRELOAD:
            begin
               if (mode)
                  nxt_lk.state = ispp_pkg::ISPP_SHIFT;
               else
               begin
                  nxt_lk.sout     = lk_ff.mcreg[MB-1];
                  nxt_lk.mcreg    = {lk_ff.mcreg[MB-2:0], serial_in};
                  nxt_lk.pre_done = ~lk_ff.pre_done;               // Event toggle
               end
            end
            ispp_pkg::ISPP_SHIFT:
            begin
               if (mode)
                  nxt_lk.state = ispp_pkg::ISPP_READ;
               else
               begin
                  nxt_lk.sout  = lk_ff.shreg[RB-1];
                  nxt_lk.shreg = {lk_ff.shreg[RB-2:0], serial_in};
               end
            end
            ispp_pkg::ISPP_READ:
            begin
               if (mode)
               begin
                  nxt_lk.state     = ispp_pkg::ISPP_WRITE;
                  nxt_lk.wr_active = 1'b1;
               end
               else
               begin
                  nxt_lk.state = ispp_pkg::ISPP_SHIFT;
                  nxt_lk.shreg = {row_rdata, addr_of(lk_ff.shreg)};
               end
            end
            ispp_pkg::ISPP_WRITE:
            begin
               if (!mode)
               begin
                  nxt_lk.state     = ispp_pkg::ISPP_READ;
                  nxt_lk.wr_active = 1'b0;
               end
               // Shift register is held throughout the write
            end
            default:
               nxt_lk.state = ispp_pkg::ISPP_NORMAL;
         endcase
      end
   end

   // Link register
   always_ff @(posedge diag_clock)
   begin
      if (!link_rstn)
      begin
         lk_ff.state     <= ispp_pkg::ISPP_NORMAL;
         lk_ff.shreg     <= ispp_pkg::SHIFT_RESET;
         lk_ff.mcreg     <= ispp_pkg::MC_RESET;
         lk_ff.sout      <= 1'b0;
         lk_ff.wr_active <= 1'b0;
         lk_ff.pre_done  <= 1'b0;
      end
      else
         lk_ff <= nxt_lk;
   end
   assign serial_out = lk_ff.sout;

   // Macrocell state lives on the system side; two link flops before capture
   ispp_sync #(.W(MB)) u_mc_sync (
      .clk  (diag_clock),
      .rstn (link_rstn),
      .ce   (1'b1),
      .d    (mc_state),
      .q    (mc_sync)
   );

   // Crossings into the system clock
   ispp_sync #(.W(3)) u_state_sync (
      .clk  (clk),
      .rstn (rstn),
      .ce   (ce),
      .d    (lk_ff.state),
      .q    (state_sync)
   );

   ispp_sync #(.W(1)) u_wr_sync (
      .clk  (clk),
      .rstn (rstn),
      .ce   (ce),
      .d    (lk_ff.wr_active),
      .q    (wr_level_sync)
   );

   ispp_sync #(.W(1)) u_pre_sync (
      .clk  (clk),
      .rstn (rstn),
      .ce   (ce),
      .d    (lk_ff.pre_done),
      .q    (pre_sync)
   );

   // System side: write strobe, macrocell preload and status
   always_comb
   begin
      nxt_sy           = sy_ff;
      nxt_sy.wr_sync   = {sy_ff.wr_sync[1:0], wr_level_sync};
      // State code taken only once two samples agree, so a code caught
      // while several bits change never reaches the outputs
      nxt_sy.st_prev = state_sync;
      if (state_sync == sy_ff.st_prev)
      begin
         nxt_sy.state_out = state_sync;
         nxt_sy.normal    = (state_sync == 3'(ispp_pkg::ISPP_NORMAL));
      end
      // Row address follows the shift register only in read, where it stands still
      if (sy_ff.state_out == 3'(ispp_pkg::ISPP_READ))
         nxt_sy.raddr = addr_of(lk_ff.shreg);
      // Write level held while the write pulse lasts
      nxt_sy.write     = sy_ff.wr_sync[0];
      if (sy_ff.wr_sync[0] && !sy_ff.wr_sync[1])
      begin
         nxt_sy.waddr = addr_of(lk_ff.shreg);
         nxt_sy.wdata = data_of(lk_ff.shreg);
      end
      // Preloaded values applied on each preload shift
      nxt_sy.wr_sync[2] = pre_sync;
      if (pre_sync != sy_ff.wr_sync[2])
      begin
         nxt_sy.mc_out   = lk_ff.mcreg;
         nxt_sy.mc_valid = 1'b1;
      end
   end

   // System register
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         sy_ff           <= '0;
         sy_ff.normal    <= 1'b1;
      end
      else if (ce)
         sy_ff <= nxt_sy;
   end

   // Outputs straight from flip-flops
   assign row_write        = sy_ff.write;
   assign row_waddr        = sy_ff.waddr;
   assign row_wdata        = sy_ff.wdata;
   assign port_state       = sy_ff.state_out;
   assign normal_mode      = sy_ff.normal;
   assign mc_preload       = sy_ff.mc_out;
   assign mc_preload_valid = sy_ff.mc_valid;
   assign row_addr         = sy_ff.raddr;
endmodule

// ### ispp_port_asserts.sv
// Assertion checker for the serial programming port outputs
`timescale 1ns/1ns
module ispp_port_asserts (
   // System clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // Observed outputs
   input wire logic        mc_preload_valid,
   input wire logic        row_write,
   input wire logic [5:0]  row_waddr,
   input wire logic [81:0] row_wdata,
   input wire logic [2:0]  port_state,
   input wire logic        normal_mode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // State code, write strobe, preload and normal flag checks
   AST_RST_NORMAL: assert property ($rose(rstn) |-> normal_mode && port_state == 3'h0)
      else $error("port not normal after reset");
   AST_STATE_LEGAL: assert property (port_state <= 3'h4)
      else $error("illegal state code");
   AST_FROM_NORMAL: assert property (($past(port_state) == 3'h0 && port_state != 3'h0)
      |-> port_state == 3'h1)
      else $error("normal left to a state other than preload");
   AST_FROM_WRITE: assert property (($past(port_state) == 3'h4 && port_state != 3'h4)
      |-> port_state inside {3'h3, 3'h0})
      else $error("write left to a wrong state");
   AST_WR_ROSE: assert property ($rose(row_write) |-> ##[0:8] port_state == 3'h4)
      else $error("row write outside write state");
   AST_WR_FALL: assert property ($fell(row_write) |-> ##[0:8] port_state != 3'h4)
      else $error("row write ended inside write state");
   AST_WR_HOLD: assert property (row_write && $past(row_write)
      |-> $stable(row_waddr) && $stable(row_wdata))
      else $error("row write word moved during write");
   AST_NO_WR_NORMAL: assert property (normal_mode [*8] |-> !row_write)
      else $error("row write while normal");
   AST_PRE_KEEP: assert property (mc_preload_valid |=> mc_preload_valid)
      else $error("preload image dropped");
   AST_NORMAL_CODE: assert property (normal_mode == (port_state == 3'h0))
      else $error("normal flag disagrees with state code");
endmodule
bind ispp_port ispp_port_asserts u_chk (.clk, .rstn, .mc_preload_valid, .row_write,
   .row_waddr, .row_wdata, .port_state, .normal_mode);

// ### ispp_host.sv
// Host model that drives the serial programming pins
`timescale 1ns/1ns
module ispp_host #(
   parameter int PROG_NS = 2000
) (
   // Link pins
   output logic      diag_clock,
   output logic      mode,
   output logic      serial_in,
   input  wire logic serial_out
);
   // Link clock rests low outside frames
   initial
   begin
      diag_clock = 1'b0;
      mode = 1'b0;
      serial_in = 1'b0;
   end
   // One 125 ns link cycle; pins change only while the clock is low
   task automatic step(input logic m, input logic s, output logic o);
      mode = m;
      serial_in = s;
      #31 diag_clock = 1'b1;
      #62 o = serial_out;
      diag_clock = 1'b0;
      #32;
   endtask
   // Row word goes data first, address last; old contents come back,
   // which a caller making a first load may disregard
   task automatic send(input logic [87:0] w, output logic [87:0] o);
      for (int i = 87; i >= 0; i--) step(1'b0, w[i], o[i]);
   endtask
   // Write time, far shorter than on a board to keep the run short
   task automatic prog_wait;
      #PROG_NS;
   endtask
endmodule

// ### test_isp_serial_program_port.sv
// Self-checking bench for the serial programming port
`timescale 1ns/1ns
module test_isp_serial_program_port;
   logic        clk, rstn, diag_clock, mode, serial_in, serial_out;
   logic        mc_preload_valid, row_write, normal_mode;
   logic [7:0]  mc_state, mc_preload, p, m0, so;
   logic [5:0]  row_addr, row_waddr;
   logic [81:0] row_rdata, row_wdata;
   logic [81:0] mem [64];
   logic [2:0]  port_state;
   logic [87:0] exp_sh, w, o;
   int          error_cnt, total_checks;
   // Units under test and host
   ispp_port DUT (.clk, .rstn, .ce(1'b1), .diag_clock, .mode, .serial_in, .serial_out,
      .mc_state, .mc_preload, .mc_preload_valid, .row_addr, .row_rdata, .row_write,
      .row_waddr, .row_wdata, .port_state, .normal_mode);
   ispp_host h (.diag_clock, .mode, .serial_in, .serial_out);
   // Clock and array model
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (row_write) mem[row_waddr] <= row_wdata;
   assign row_rdata = mem[row_addr];
   // Compare and closing report
   task automatic chk(input string n, input logic [87:0] e, input logic [87:0] s);
      total_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wst(input logic [2:0] e);
      int i;
      i = 0;
      while (port_state !== e && i < 40)
      begin
         @(negedge clk);
         i++;
      end
      chk("port_state", e, port_state);
      if (port_state !== e) test_done();
   endtask
   // Main sequence
   initial
   begin
      error_cnt = 0;
      total_checks = 0;
      rstn = 1'b0;
      mc_state = 8'h00;
      exp_sh = 88'h0;
      foreach (mem[i]) mem[i] = 82'h0;
      void'($urandom(17));
      repeat (20) @(negedge clk);
      repeat (2) h.step(1'b0, 1'b0, o[0]);
      @(negedge clk);
      rstn = 1'b1;
      repeat (2) h.step(1'b0, 1'b0, o[0]);
      chk("normal_mode", 1, normal_mode);
      wst(3'h0);
      // Preload: capture, shift test data, leave by user reset
      @(negedge clk);
      m0 = 8'($urandom);
      p = 8'($urandom);
      mc_state = m0;
      repeat (2) h.step(1'b0, 1'b0, o[0]);
      h.step(1'b1, 1'b1, o[0]);
      wst(3'h1);
      for (int i = 7; i >= 0; i--) h.step(1'b0, p[i], so[i]);
      chk("mc_out", m0, so);
      h.step(1'b1, 1'b0, o[0]);
      wst(3'h0);
      repeat (8) @(negedge clk);
      chk("mc_preload", p, mc_preload);
      chk("mc_valid", 1, mc_preload_valid);
      // Program and verify two rows, then read the last one back
      h.step(1'b1, 1'b1, o[0]);
      h.step(1'b1, 1'b1, o[0]);
      wst(3'h2);
      chk("normal_mode", 0, normal_mode);
      for (int r = 0; r < 3; r++)
      begin
         w = 88'({$urandom, $urandom, $urandom});
         h.send(w, o);
         chk("shift_out", exp_sh, o);
         exp_sh = w;
         if (r == 2) break;
         h.step(1'b1, 1'b1, o[0]);
         wst(3'h3);
         h.step(1'b1, 1'b1, o[0]);
         wst(3'h4);
         repeat (8) @(negedge clk);
         chk("row_write", 1, row_write);
         chk("row_waddr", w[5:0], row_waddr);
         chk("row_wdata", w[87:6], row_wdata);
         h.step(1'b1, 1'b1, o[0]);
         wst(3'h4);
         h.prog_wait();
         h.step(1'b0, 1'b1, o[0]);
         wst(3'h3);
         repeat (8) @(negedge clk);
         chk("row_write", 0, row_write);
         chk("row_addr", w[5:0], row_addr);
         h.step(1'b0, 1'b0, o[0]);
         wst(3'h2);
      end
      test_done();
   end
endmodule
